// File: bench/dbs_bridge_bench.sv
// self-checking bench for the bus width adapter
`timescale 1ns/1ps
module dbs_bridge_bench;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req_valid = 1'b0;
  logic i_rsp_ready = 1'b0;
  dbs_pkg::dbs_req_t i_req = '0;
  dbs_pkg::dbs_rsp_t o_rsp;
  dbs_pkg::dbs_req_t c;
  logic o_req_ready, o_rsp_valid, o_bus_start, o_bus_write, o_bus_io;
  logic [29:0] o_word_address;
  logic [3:0] o_lane_select_n, o_data_lines_oe;
  logic [31:0] i_data_lines, o_data_lines, m, v;
  logic i_bus_ready_n, i_eight_bit_port_n, i_sixteen_bit_port_n;
  logic hold_rsp = 1'b1;
  logic [33:0] r;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 32'h7e4c;
  dbs_pkg::dbs_req_t exp_cyc[$];
  logic [33:0] exp_rsp[$];

  always #25 i_core_clk = ~i_core_clk;

  dbs_bridge u_dbs_bridge (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req(i_req), .o_rsp_valid(o_rsp_valid),
    .i_rsp_ready(i_rsp_ready), .o_rsp(o_rsp), .o_bus_start(o_bus_start),
    .o_bus_write(o_bus_write), .o_bus_io(o_bus_io), .o_word_address(o_word_address),
    .o_lane_select_n(o_lane_select_n), .i_data_lines(i_data_lines),
    .o_data_lines(o_data_lines), .o_data_lines_oe(o_data_lines_oe),
    .i_bus_ready_n(i_bus_ready_n), .i_eight_bit_port_n(i_eight_bit_port_n),
    .i_sixteen_bit_port_n(i_sixteen_bit_port_n));

  dbs_target_model u_dbs_target_model (.i_core_clk(i_core_clk), .i_bus_start(o_bus_start),
    .i_word_address(o_word_address), .i_lane_select_n(o_lane_select_n),
    .o_bus_ready_n(i_bus_ready_n), .o_eight_bit_port_n(i_eight_bit_port_n),
    .o_sixteen_bit_port_n(i_sixteen_bit_port_n), .o_data_lines(i_data_lines));

  ////////////////////////////////////////////////////////////////////////////
  task chk_cycle(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task chk_answer(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // notes the expected bus cycles and answer, then hands the request over
  task send(input logic wr, input logic io, input logic [29:0] a, input logic [3:0] ln,
            input int mode);
    logic [3:0] act;
    logic [3:0] low;
    logic [3:0] mv;
    logic [31:0] wd;
    logic [31:0] rd;
    logic ok;
    int w;
    int k;
    dbs_pkg::dbs_req_t e;
    wd = $random(seed);
    rd = 32'h0;
    act = ~ln;
    low = act & -act;
    ok = (act != 4'h0) && (((act + low) & act) == 4'h0);
    e = '{write: wr, io: io, word_address: io ? {16'h0, a[13:0]} : a, lane_select_n: ln,
          wdata: wd};
    while (ok && act != 4'h0) begin
      w = (mode < 4) ? mode : ($random(seed) & 3);
      low = act & -act;
      mv = (w == 0) ? act : (w >= 2) ? low :
           (act[1:0] != 2'h0) ? (act & 4'h3) : (act & 4'hc);
      e.lane_select_n = ~act;
      exp_cyc.push_back(e);
      u_dbs_target_model.wq.push_back(w + 4 * ($random(seed) & 3));
      for (k = 0; k < 4; k++) begin
        if (mv[k]) rd[8*k+:8] = 8'h5a ^ {e.word_address[5:0], k[1:0]};
      end
      act = act & ~mv;
    end
    exp_rsp.push_back({!wr, rd, !ok});
    @(posedge i_core_clk);
    #1 i_req = '{write: wr, io: io, word_address: a, lane_select_n: ln, wdata: wd};
    i_req_valid = 1'b1;
    k = 0;
    @(posedge i_core_clk);
    while (o_req_ready !== 1'b1 && k < 400) begin
      @(posedge i_core_clk);
      k++;
    end
    if (k == 400) begin
      n_fail++;
      end_sim();
    end
    #1 i_req_valid = 1'b0;
  endtask

  task drain;
    int k;
    for (k = 0; k < 4000 && (exp_rsp.size() != 0 || exp_cyc.size() != 0); k++) begin
      @(posedge i_core_clk);
    end
    if (k == 4000) begin
      n_fail++;
      end_sim();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_core_clk) i_rsp_ready <= #1 !hold_rsp && ($random(seed) % 3 != 0);

  always @(posedge i_core_clk) begin
    if (!i_rst && o_bus_start) begin
      if (exp_cyc.size() == 0) chk_cycle("unexpected bus cycle", 32'h0, 32'h1);
      else begin
        c = exp_cyc.pop_front();
        for (int l = 0; l < 4; l++) m[8*l+:8] = {8{c.write & ~c.lane_select_n[l]}};
        chk_cycle("lane selects", c.lane_select_n, o_lane_select_n);
        chk_cycle("word address", c.word_address, o_word_address);
        chk_cycle("write and io", {c.write, c.io}, {o_bus_write, o_bus_io});
        chk_cycle("lane enables", {28'h0, c.write ? ~c.lane_select_n : 4'h0},
                  {28'h0, o_data_lines_oe});
        chk_cycle("write data", c.wdata & m, o_data_lines & m);
      end
    end
    if (!i_rst && o_rsp_valid && i_rsp_ready) begin
      if (exp_rsp.size() == 0) chk_answer("unexpected answer", 32'h0, 32'h1);
      else begin
        r = exp_rsp.pop_front();
        chk_answer("answer error flag", r[0], o_rsp.err);
        if (r[33]) chk_answer("read data", r[32:1], o_rsp.rdata);
      end
    end
  end

  initial begin
    repeat (20) @(posedge i_core_clk);
    #1 i_rst = 1'b0;
    hold_rsp = 1'b0;
    send(1'b0, 1'b0, 30'h3fff_ffff, 4'h0, 2);
    send(1'b1, 1'b1, 30'h3fff_ffff, 4'h0, 1);
    for (int rnd = 0; rnd < 6; rnd++) begin
      for (int p = 0; p < 16; p++) begin
        v = $random(seed);
        send(v[0], v[1], v[31:2], p[3:0], rnd);
      end
    end
    drain();
    // answer buffer fills while the core stalls
    hold_rsp = 1'b1;
    send(1'b0, 1'b0, 30'h1, 4'h5, 0);
    send(1'b0, 1'b0, 30'h2, 4'hf, 0);
    // third answer finds the buffer full and holds the sequencer
    send(1'b0, 1'b0, 30'h4, 4'ha, 0);
    repeat (10) @(posedge i_core_clk);
    chk_answer("request ready when full", 32'h0, {31'h0, o_req_ready});
    chk_answer("answer valid when full", 32'h1, {31'h0, o_rsp_valid});
    #1 hold_rsp = 1'b0;
    send(1'b0, 1'b0, 30'h3, 4'h3, 3);
    drain();
    end_sim();
  end
endmodule

// File: bench/dbs_target_model.sv
// far-side target model: answers each bus cycle at a chosen width
`timescale 1ns/1ps
module dbs_target_model (
  // from the bridge
  input wire logic i_core_clk,
  input wire logic i_bus_start,
  input wire logic [29:0] i_word_address,
  input wire logic [3:0] i_lane_select_n,
  // to the bridge
  output logic o_bus_ready_n,
  output logic o_eight_bit_port_n,
  output logic o_sixteen_bit_port_n,
  output logic [31:0] o_data_lines
);
  // entry: width code in bits 1:0, wait cycles above
  int wq[$];
  int e;
  logic [3:0] act;
  logic [3:0] mv;
  logic addr_bit1;
  logic low_byte_strobe_n;
  logic high_byte_strobe_n;
  initial begin
    o_bus_ready_n = 1'b1;
    o_eight_bit_port_n = 1'b1;
    o_sixteen_bit_port_n = 1'b1;
    o_data_lines = 32'h0;
    forever begin
      @(posedge i_core_clk);
      if (i_bus_start) begin
        e = wq.pop_front();
        act = ~i_lane_select_n;
        // narrow-side address bit 1 and byte strobes, as the outside decoder makes them
        addr_bit1 = !(act[0] | act[1]);
        low_byte_strobe_n = !(act[0] | (act[2] & !act[1]));
        high_byte_strobe_n = !(act[1] | act[3]);
        // bytes this width can route onto their own lanes
        mv = (e % 4 == 0) ? act : (e % 4 >= 2) ? (4'h1 << {addr_bit1, low_byte_strobe_n}) :
             addr_bit1 ? {!high_byte_strobe_n, !low_byte_strobe_n, 2'h0} :
             {2'h0, !high_byte_strobe_n, !low_byte_strobe_n};
        repeat (e / 4) begin
          #1 o_data_lines = ~o_data_lines;
          @(posedge i_core_clk);
        end
        #1 o_bus_ready_n = 1'b0;
        o_eight_bit_port_n = !(e % 4 >= 2);
        o_sixteen_bit_port_n = !(e % 4 == 1 || e % 4 == 3);
        for (int l = 0; l < 4; l++) begin
          o_data_lines[8*l+:8] = mv[l] ? (8'h5a ^ {i_word_address[5:0], l[1:0]}) :
                                 ~o_data_lines[8*l+:8];
        end
        repeat (4) @(posedge i_core_clk);
        #1 o_bus_ready_n = 1'b1;
        o_eight_bit_port_n = 1'b1;
        o_sixteen_bit_port_n = 1'b1;
      end
      // released lines never keep the last value
      #1 o_data_lines = ~o_data_lines;
    end
  end
endmodule

// File: verilog/dbs_bridge.sv
// bus width adapter: splits requests into 32, 16 or 8 bit bus cycles
// What this block does
// - memory requests reach the full 32-bit byte space.
// - i/o requests stay inside a 64 kbyte space.
// - lowest byte of a word on lines 7-0, highest on 31-24.
// - width inputs are sampled in every bus cycle.
// - both width inputs asserted means an 8-bit target.
// - 16-bit width splits a word into two cycles.
// - 8-bit width splits a word into four byte cycles.
// - word address holds steady across the extra cycles.
// - 8-bit next lane patterns follow the byte step table.
// - 16-bit next lane patterns follow the half step table.
// - a request ends with no further cycle once satisfied.
// - 8-bit read takes the byte of the lowest active lane.
// - 16-bit read takes active lanes of the lower enabled half.
// - write data driven only on lanes whose select is active.
// - a lane select is asserted only when its byte takes part, except for one clock after a refused request is taken.
// - no negated select between asserted selects appears, except for one clock after a refused request is taken.
`timescale 1ns/1ps
module dbs_bridge (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // request from the core
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire dbs_pkg::dbs_req_t i_req,
  // answer to the core
  output logic o_rsp_valid,
  input wire logic i_rsp_ready,
  output dbs_pkg::dbs_rsp_t o_rsp,
  // bus cycle outputs
  output logic o_bus_start,
  output logic o_bus_write,
  output logic o_bus_io,
  output logic [dbs_pkg::WADDR_W-1:0] o_word_address,
  output logic [dbs_pkg::LANES-1:0] o_lane_select_n,
  // data lines, split per lane
  input wire logic [dbs_pkg::DATA_W-1:0] i_data_lines,
  output logic [dbs_pkg::DATA_W-1:0] o_data_lines,
  output logic [dbs_pkg::LANES-1:0] o_data_lines_oe,
  // cycle end and width inputs
  input wire logic i_bus_ready_n,
  input wire logic i_eight_bit_port_n,
  input wire logic i_sixteen_bit_port_n
);
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WAIT, ST_RESP} dbs_state_t;

  dbs_state_t state_q;
  dbs_pkg::dbs_req_t req_q;
  logic [3:0] lanes_q;
  logic [dbs_pkg::DATA_W-1:0] rdata_q;
  logic err_q;
  logic start_q;
  logic [dbs_pkg::DATA_W-1:0] dout_q;
  logic [3:0] oe_q;
  logic [dbs_pkg::SYNC_W-1:0] s1_q;
  logic [dbs_pkg::SYNC_W-1:0] s2_q;
  logic [dbs_pkg::SYNC_W-1:0] s3_q;
  logic [dbs_pkg::SYNC_W-1:0] filt_q;
  logic rdy_prev_q;
  logic rdy_n_f;
  logic nb8;
  logic nb16;
  logic [dbs_pkg::DATA_W-1:0] data_f;
  logic done_ev;
  logic [3:0] xfer;
  logic [3:0] next_n;
  logic last;
  logic buf_ready;
  logic buf_valid;
  dbs_pkg::dbs_rsp_t buf_in;
  dbs_pkg::dbs_req_t req_in;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers with agreement filter

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      filt_q <= '1;
    end else begin
      s1_q <= {i_sixteen_bit_port_n, i_eight_bit_port_n, i_bus_ready_n, i_data_lines};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < dbs_pkg::SYNC_W; i++) begin
        if (s2_q[i] == s3_q[i]) filt_q[i] <= s3_q[i];
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) rdy_prev_q <= 1'b1;
    else rdy_prev_q <= rdy_n_f;
  end

  assign rdy_n_f = filt_q[dbs_pkg::SYNC_RDY];
  assign nb8 = ~filt_q[dbs_pkg::SYNC_BS8];
  assign nb16 = ~filt_q[dbs_pkg::SYNC_SIXTEEN_BIT_PORT_N];
  assign data_f = filt_q[dbs_pkg::DATA_W-1:0];
  // cycle end is the falling edge of the filtered ready
  assign done_ev = (state_q == ST_WAIT) && rdy_prev_q && !rdy_n_f;

  ////////////////////////////////////////////////////////////////////
  // lane stepping, width taken fresh at each cycle end

  dbs_lane_step u_step (
    .i_lane_select_n(lanes_q),
    .i_narrow8(nb8),
    .i_narrow16(nb16),
    .o_xfer(xfer),
    .o_next_n(next_n),
    .o_last(last)
  );

  ////////////////////////////////////////////////////////////////////
  // request intake, i/o addresses folded into 64 kbyte

  always_comb begin
    req_in = i_req;
    if (i_req.io) begin
      req_in.word_address[dbs_pkg::WADDR_W-1:dbs_pkg::IO_WADDR_W] = '0;
    end
  end

  assign o_req_ready = (state_q == ST_IDLE);

  ////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (i_req_valid) begin
            state_q <= dbs_pkg::lanes_ok(i_req.lane_select_n) ? ST_ADDR : ST_RESP;
          end
        end
        ST_ADDR: begin
          if (rdy_n_f) state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (done_ev) state_q <= last ? ST_RESP : ST_ADDR;
        end
        ST_RESP: begin
          if (buf_ready) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // request held for all its cycles, word address never moves
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      req_q <= '0;
      err_q <= 1'b0;
    end else if (state_q == ST_IDLE && i_req_valid) begin
      req_q <= req_in;
      err_q <= !dbs_pkg::lanes_ok(i_req.lane_select_n);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      lanes_q <= dbs_pkg::LANES_NONE_N;
    end else if (state_q == ST_IDLE && i_req_valid) begin
      lanes_q <= i_req.lane_select_n;
    end else if (done_ev && !last) begin
      lanes_q <= next_n;
    end else if (state_q == ST_RESP) begin
      lanes_q <= dbs_pkg::LANES_NONE_N;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bus cycle start and write drive

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) start_q <= 1'b0;
    else start_q <= (state_q == ST_ADDR) && rdy_n_f;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      dout_q <= dbs_pkg::DATA_RST;
      oe_q <= 4'h0;
    end else if (state_q == ST_ADDR) begin
      for (int l = 0; l < dbs_pkg::LANES; l++) begin
        // no copies onto lanes that are not selected
        dout_q[l*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W] <= lanes_q[l] ? 8'h00 :
            req_q.wdata[l*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W];
      end
      oe_q <= req_q.write ? ~lanes_q : 4'h0;
    end else if (done_ev || state_q == ST_RESP) begin
      oe_q <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read capture on the addressed lanes

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= dbs_pkg::DATA_RST;
    end else if (state_q == ST_IDLE && i_req_valid) begin
      rdata_q <= dbs_pkg::DATA_RST;
    end else if (done_ev && !req_q.write) begin
      for (int l = 0; l < dbs_pkg::LANES; l++) begin
        if (xfer[l]) begin
          rdata_q[l*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W] <=
              data_f[l*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // answer buffer; a full buffer holds the sequencer in ST_RESP

  assign buf_valid = (state_q == ST_RESP);
  assign buf_in.rdata = rdata_q;
  assign buf_in.err = err_q;

  dbs_buf2 #(
    .W($bits(dbs_pkg::dbs_rsp_t))
  ) u_buf (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_valid(buf_valid),
    .o_ready(buf_ready),
    .i_data(buf_in),
    .o_valid(o_rsp_valid),
    .i_ready(i_rsp_ready),
    .o_data(o_rsp)
  );

  assign o_bus_start = start_q;
  assign o_bus_write = req_q.write;
  assign o_bus_io = req_q.io;
  assign o_word_address = req_q.word_address;
  assign o_lane_select_n = lanes_q;
  assign o_data_lines = dout_q;
  assign o_data_lines_oe = oe_q;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_io_addr_range: assert property (o_bus_start && o_bus_io |->
      o_word_address[dbs_pkg::WADDR_W-1:dbs_pkg::IO_WADDR_W] == '0)
    else $error("io address above 64 kbyte");

  a_lane_contiguous: assert property (o_bus_start |-> dbs_pkg::lanes_ok(o_lane_select_n))
    else $error("broken lane pattern on bus");

  a_addr_hold_narrow: assert property (done_ev && !last |=> $stable(o_word_address))
    else $error("word address moved within request");

  a_step_byte_wide: assert property (done_ev && nb8 && lanes_q == 4'hc |=>
      lanes_q == 4'hd ##1 o_lane_select_n == 4'hd)
    else $error("wrong byte step");

  a_step_half_wide: assert property (done_ev && !nb8 && nb16 && lanes_q == 4'h8 |=>
      lanes_q == 4'hb)
    else $error("wrong half step");

  a_both_means_byte: assert property (done_ev && nb8 && nb16 && lanes_q == 4'h0 |=>
      lanes_q == 4'h1)
    else $error("both widths not byte wide");

  a_single_ends: assert property (done_ev && (nb8 || nb16) && lanes_q == 4'hd |=>
      state_q == ST_RESP)
    else $error("extra cycle after satisfied request");

  a_write_lanes_only: assert property ((o_data_lines_oe & o_lane_select_n) == 4'h0)
    else $error("write drive on negated lane");

  a_read_low_byte: assert property (done_ev && !req_q.write && nb8 && lanes_q == 4'h8 |=>
      rdata_q[7:0] == $past(data_f[7:0]) && lanes_q == 4'h9)
    else $error("byte read lane wrong");

  a_read_high_half: assert property (done_ev && !req_q.write && !nb8 && nb16 && lanes_q == 4'h3
      |=> rdata_q[31:16] == $past(data_f[31:16]))
    else $error("half read lanes wrong");

  a_one_request: assert property (done_ev && !last |=>
      state_q == ST_ADDR && !o_req_ready)
    else $error("request left before all bytes moved");

  a_start_pulse: assert property (o_bus_start |=> !o_bus_start && state_q == ST_WAIT)
    else $error("start not a single pulse");

  c_byte_split: cover property (done_ev && nb8 && lanes_q == 4'h7);
  c_half_split: cover property (done_ev && !nb8 && nb16 && lanes_q == 4'h0 && !last);
  c_full_word: cover property (done_ev && !nb8 && !nb16 && lanes_q == 4'h0);
  c_refused: cover property (o_rsp_valid && o_rsp.err);
endmodule

// File: verilog/dbs_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module dbs_buf2 #(
  parameter int W = 33
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  logic [W-1:0] mem_q [2];
  logic wptr_q;
  logic rptr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  initial begin
    if (W < 1) $error("buffer width must be positive");
  end

  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data = mem_q[rptr_q];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wptr_q] <= i_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wptr_q <= ~wptr_q;
      if (pop) rptr_q <= ~rptr_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// File: verilog/dbs_lane_step.sv
// lanes moved in this cycle and lanes left for the next one
`timescale 1ns/1ps
module dbs_lane_step (
  // current cycle
  input wire logic [3:0] i_lane_select_n,
  input wire logic i_narrow8,
  input wire logic i_narrow16,
  // outcome
  output logic [3:0] o_xfer,
  output logic [3:0] o_next_n,
  output logic o_last
);
  logic [3:0] act;
  logic [3:0] low;
  logic [3:0] half;
  logic [3:0] rem;

  assign act = ~i_lane_select_n;
  assign low = act & (~act + 4'h1);
  assign half = (act[1:0] != 2'h0) ? {2'h0, act[1:0]} : {act[3:2], 2'h0};
  // both widths asserted means byte wide
  assign o_xfer = i_narrow8 ? low : (i_narrow16 ? half : act);
  assign rem = act & ~o_xfer;
  assign o_last = (rem == 4'h0);
  assign o_next_n = ~rem;
endmodule

// File: verilog/dbs_pkg.sv
// shared constants, carriers and lane helpers for the bus width adapter
package dbs_pkg;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int DATA_W = LANES * BYTE_W;
  localparam int WADDR_W = 30;
  localparam int IO_WADDR_W = 14;
  localparam int SYNC_W = DATA_W + 3;
  localparam int SYNC_RDY = DATA_W;
  localparam int SYNC_BS8 = DATA_W + 1;
  localparam int SYNC_SIXTEEN_BIT_PORT_N = DATA_W + 2;
  localparam logic [3:0] LANES_NONE_N = 4'hf;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

  typedef struct packed {
    logic write;
    logic io;
    logic [WADDR_W-1:0] word_address;
    logic [LANES-1:0] lane_select_n;
    logic [DATA_W-1:0] wdata;
  } dbs_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic err;
  } dbs_rsp_t;

  // at least one lane, and no negated lane between asserted ones
  function automatic logic lanes_ok(input logic [LANES-1:0] sel_n);
    logic [LANES-1:0] a;
    a = ~sel_n;
    case (a)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf: lanes_ok = 1'b1;
      default: lanes_ok = 1'b0;
    endcase
  endfunction
endpackage
